//--- hdl/pit_top.sv
// apb register file, clock prescaler and channels of the timer block
// assumes a single 250 mhz clock and pins already synchronous to it
//
// The placing of the registers and register access over APB were left to the implementer.
`include "pit_map.svh"
module pit_top (
	input wire logic core_clk_in,
	input wire logic reset_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic general_trigger_input_in,
	output logic modulated_output_pin_out,
	input wire logic [2:0] interval_event_input_in,
	input wire logic [2:0] interval_event_alt_in,
	input wire logic main_oscillator_input_in
);
	pit_pkg::pit_top_t s_r;
	pit_pkg::pit_top_t s_nxt;
	logic done;
	logic wr_go;
	logic wr_pwm;
	logic [2:0] wr_iv;
	logic [2:0] iv_irq;
	logic [15:0] iv_cnt [3];
	logic pwm_irq;
	logic pwm_tick;
	logic [2:0] iv_tick;
	logic [2:0] iv_evt;
	logic osc_rise;
	logic [31:0] rdata;
	logic mapped;

	// count clock chosen by mode bits 7:6 from the free prescaler
	function automatic logic sel_tick(input logic [1:0] sel, input logic [8:0] pre);
		logic t;
		unique case (sel)
			2'b00: t = 1'b1;
			2'b01: t = &pre[2:0];
			2'b10: t = &pre[4:0];
			default: t = &pre[8:0];
		endcase
		return t;
	endfunction : sel_tick

	always_comb begin
		mapped = 1'b1;
		rdata = 32'h0000_0000;
		unique case (paddr_in)
			`PIT_OFS_START: rdata = {24'h00_0000, s_r.start};
			`PIT_OFS_PWM_MODE: rdata = {24'h00_0000, s_r.pwm_mode};
			`PIT_OFS_PWM_DATA: rdata = 32'h0000_0000;
			`PIT_OFS_IRQ: rdata = {24'h00_0000, s_r.irq_stat};
			`PIT_OFS_FSEL: rdata = {24'h00_0000, s_r.fsel};
			`PIT_OFS_PINSEL: rdata = {29'h0000_0000, s_r.pinsel};
			`PIT_OFS_IV_MODE0: rdata = {24'h00_0000, s_r.iv_mode[7:0]};
			`PIT_OFS_IV_MODE0 + 8'h04: rdata = {24'h00_0000, s_r.iv_mode[15:8]};
			`PIT_OFS_IV_MODE0 + 8'h08: rdata = {24'h00_0000, s_r.iv_mode[23:16]};
			`PIT_OFS_IV_DATA0: rdata = {16'h0000, iv_cnt[0]};
			`PIT_OFS_IV_DATA0 + 8'h04: rdata = {16'h0000, iv_cnt[1]};
			`PIT_OFS_IV_DATA0 + 8'h08: rdata = {16'h0000, iv_cnt[2]};
			default: mapped = 1'b0;
		endcase
	end

	// one wait state: setup, access, access with pready
	assign done = psel_in & penable_in & s_r.pready;
	assign wr_go = done & pwrite_in & mapped;
	assign wr_pwm = wr_go && paddr_in == `PIT_OFS_PWM_DATA;
	assign osc_rise = main_oscillator_input_in & ~s_r.osc_q;
	assign pwm_tick = sel_tick(s_r.pwm_mode[7:6], s_r.pre);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_iv
			assign wr_iv[gi] = wr_go && paddr_in == `PIT_OFS_IV_DATA0 + 8'(4 * gi);
			assign iv_tick[gi] = sel_tick(s_r.iv_mode[8*gi+7 -: 2], s_r.pre);
			assign iv_evt[gi] = s_r.pinsel[gi] ? interval_event_alt_in[gi]
				: interval_event_input_in[gi];
			pit_iv_chan #(
				.CW(16)
			) u_iv (
				.clk_in(core_clk_in),
				.rst_n_in(reset_n_in),
				.tick_in(iv_tick[gi]),
				.osc_tick_in(s_r.osc_tick),
				.use_osc_in(gi == 2 && s_r.fsel[`PIT_FSEL_OSC_BIT]),
				.start_in(s_r.start[`PIT_START_IV_LSB + gi]),
				.mode_in(s_r.iv_mode[8*gi +: 8]),
				.wr_in(wr_iv[gi]),
				.wdata_in(pwdata_in[15:0]),
				.evt_in(iv_evt[gi]),
				.cnt_out(iv_cnt[gi]),
				.irq_out(iv_irq[gi])
			);
		end
	endgenerate

	pit_pwm_chan u_pwm (
		.clk_in(core_clk_in),
		.rst_n_in(reset_n_in),
		.tick_in(pwm_tick),
		.start_in(s_r.start[`PIT_START_PWM_BIT]),
		.mode_in(s_r.pwm_mode),
		.wr_in(wr_pwm),
		.wdata_in(pwdata_in[15:0]),
		.trig_in(general_trigger_input_in),
		.out_out(modulated_output_pin_out),
		.irq_out(pwm_irq)
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.pre = s_r.pre + 9'h001;
		s_nxt.osc_q = main_oscillator_input_in;
		s_nxt.osc_tick = 1'b0;
		if (osc_rise) begin
			s_nxt.osc_cnt = s_r.osc_cnt + 5'h01;
			s_nxt.osc_tick = (s_r.osc_cnt == `PIT_OSC_LAST);
		end
		s_nxt.pready = psel_in & penable_in & ~s_r.pready;
		if (psel_in && penable_in && !s_r.pready) begin
			s_nxt.prdata = rdata;
			s_nxt.pslverr = ~mapped;
		end
		if (!psel_in) begin
			s_nxt.prdata = 32'h0000_0000;
			s_nxt.pslverr = 1'b0;
		end
		if (wr_go) begin
			unique case (paddr_in)
				`PIT_OFS_START: s_nxt.start = pwdata_in[7:0];
				`PIT_OFS_PWM_MODE: s_nxt.pwm_mode = pwdata_in[7:0];
				`PIT_OFS_IRQ: s_nxt.irq_stat = s_r.irq_stat & ~pwdata_in[7:0];
				`PIT_OFS_FSEL: s_nxt.fsel = pwdata_in[7:0];
				`PIT_OFS_PINSEL: s_nxt.pinsel = pwdata_in[2:0];
				`PIT_OFS_IV_MODE0: s_nxt.iv_mode[7:0] = pwdata_in[7:0];
				`PIT_OFS_IV_MODE0 + 8'h04: s_nxt.iv_mode[15:8] = pwdata_in[7:0];
				`PIT_OFS_IV_MODE0 + 8'h08: s_nxt.iv_mode[23:16] = pwdata_in[7:0];
				default: ;
			endcase
		end
		// hardware set wins over a clear in the same cycle
		if (pwm_irq)
			s_nxt.irq_stat[`PIT_IRQ_PWM_BIT] = 1'b1;
		for (int i = 0; i < 3; i++) begin
			if (iv_irq[i])
				s_nxt.irq_stat[`PIT_IRQ_IV_LSB + i] = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			s_r <= '0;
			s_r.start <= `PIT_RST_REG;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata_out = s_r.prdata;
	assign pready_out = s_r.pready;
	assign pslverr_out = s_r.pslverr;

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	a_apb_wait: assert property (psel_in && penable_in && !pready_out
		|=> pready_out ##1 !pready_out)
		else $error("apb answer not one wait state");
	a_irq_set_wins: assert property (pwm_irq |=> s_r.irq_stat[`PIT_IRQ_PWM_BIT])
		else $error("modulator request lost");
	a_iv_sticky: assert property (iv_irq[0] || s_r.irq_stat[`PIT_IRQ_IV_LSB]
		&& !(wr_go && paddr_in == `PIT_OFS_IRQ && pwdata_in[`PIT_IRQ_IV_LSB])
		|=> s_r.irq_stat[`PIT_IRQ_IV_LSB])
		else $error("interval request not sticky");
	a_start_shared: assert property (wr_go && paddr_in == `PIT_OFS_START
		|=> s_r.start == $past(pwdata_in[7:0]))
		else $error("count start register not written");
	a_osc_div: assert property (s_r.osc_tick
		|-> $past(s_r.osc_cnt) == `PIT_OSC_LAST && s_r.osc_cnt == 5'h00)
		else $error("oscillator divide wrong");
	c_apb_write: cover property (wr_go);
	c_apb_err: cover property (pslverr_out && pready_out);
endmodule : pit_top

//--- hdl/pit_map.svh
// register offsets, field positions, reset values and counts of the timer block
// assumes a 32-bit apb slave with byte addresses in paddr[7:0]
`ifndef PIT_MAP_SVH
`define PIT_MAP_SVH
`define PIT_OFS_START 8'h00
`define PIT_OFS_PWM_MODE 8'h04
`define PIT_OFS_PWM_DATA 8'h08
`define PIT_OFS_IRQ 8'h0c
`define PIT_OFS_FSEL 8'h10
`define PIT_OFS_PINSEL 8'h14
`define PIT_OFS_IV_MODE0 8'h20
`define PIT_OFS_IV_DATA0 8'h30
`define PIT_START_PWM_BIT 0
`define PIT_START_IV_LSB 5
`define PIT_IRQ_PWM_BIT 0
`define PIT_IRQ_IV_LSB 5
`define PIT_FSEL_OSC_BIT 6
`define PIT_MODE_W8_BIT 5
`define PIT_MODE_TRIG_BIT 4
`define PIT_MODE_EDGE_BIT 3
`define PIT_RST_REG 8'h00
`define PIT_PWM_LAST16 16'hfffe
`define PIT_PWM_LAST8 16'h00fe
`define PIT_OSC_LAST 5'h1f
`endif

//--- hdl/pit_pkg.sv
// state types of the modulator, the interval channels and the register file
// assumes nothing beyond the sv compiler
package pit_pkg;
	typedef enum logic [1:0] {
		PIT_IDLE = 2'b00,
		PIT_ARMED = 2'b01,
		PIT_RUN = 2'b11
	} pit_pwm_st_t;
	typedef struct packed {
		pit_pwm_st_t st;
		logic [15:0] reload;
		logic [15:0] cnt;
		logic [15:0] pc;
		logic [7:0] psc;
		logic trig_q;
		logic out;
		logic irq;
	} pit_pwm_t;
	typedef struct packed {
		logic [15:0] reload;
		logic [15:0] cnt;
		logic evt_q;
		logic irq;
	} pit_iv_t;
	typedef struct packed {
		logic [7:0] start;
		logic [7:0] pwm_mode;
		logic [23:0] iv_mode;
		logic [7:0] fsel;
		logic [2:0] pinsel;
		logic [7:0] irq_stat;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [8:0] pre;
		logic osc_q;
		logic [4:0] osc_cnt;
		logic osc_tick;
	} pit_top_t;
endpackage : pit_pkg

//--- hdl/pit_pwm_chan.sv
// pulse width modulator channel, 16-bit or 8-bit with prescaler
// assumes tick_in is a one-cycle pulse of the selected count clock
`include "pit_map.svh"
module pit_pwm_chan (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic tick_in,
	input wire logic start_in,
	input wire logic [7:0] mode_in,
	input wire logic wr_in,
	input wire logic [15:0] wdata_in,
	input wire logic trig_in,
	output logic out_out,
	output logic irq_out
);
	pit_pkg::pit_pwm_t s_r;
	pit_pkg::pit_pwm_t s_nxt;
	logic pwm_sel;
	logic edge_ok;
	logic w8;
	logic mtick;
	logic [15:0] width;
	always_comb begin
		s_nxt = s_r;
		s_nxt.irq = 1'b0;
		s_nxt.trig_q = trig_in;
		pwm_sel = &mode_in[2:0];
		w8 = mode_in[`PIT_MODE_W8_BIT];
		edge_ok = mode_in[`PIT_MODE_EDGE_BIT] ? (trig_in & ~s_r.trig_q)
			: (~trig_in & s_r.trig_q);
		mtick = 1'b0;
		if (wr_in) begin
			s_nxt.reload = wdata_in;
			if (s_r.st != pit_pkg::PIT_RUN)
				s_nxt.cnt = wdata_in;
		end
		unique case (s_r.st)
			pit_pkg::PIT_IDLE: begin
				if (start_in && pwm_sel) begin
					s_nxt.pc = 16'h0000;
					s_nxt.psc = s_nxt.cnt[7:0];
					s_nxt.st = mode_in[`PIT_MODE_TRIG_BIT] ? pit_pkg::PIT_ARMED
						: pit_pkg::PIT_RUN;
				end
			end
			pit_pkg::PIT_ARMED: begin
				if (!start_in || !pwm_sel)
					s_nxt.st = pit_pkg::PIT_IDLE;
				else if (edge_ok) begin
					// prescaler may have been rewritten while armed
					s_nxt.psc = s_nxt.cnt[7:0];
					s_nxt.st = pit_pkg::PIT_RUN;
				end
			end
			pit_pkg::PIT_RUN: begin
				if (!start_in || !pwm_sel) begin
					s_nxt.st = pit_pkg::PIT_IDLE;
				end else begin
					// triggers are not looked at here
					if (w8) begin
						if (tick_in) begin
							if (s_r.psc == 8'h00) begin
								s_nxt.psc = s_r.reload[7:0];
								mtick = 1'b1;
							end else begin
								s_nxt.psc = s_r.psc - 8'h01;
							end
						end
					end else begin
						mtick = tick_in;
					end
					if (mtick) begin
						if (s_r.pc == (w8 ? `PIT_PWM_LAST8 : `PIT_PWM_LAST16)) begin
							s_nxt.pc = 16'h0000;
							s_nxt.cnt = s_r.reload;
						end else begin
							s_nxt.pc = s_r.pc + 16'h0001;
						end
					end
				end
			end
			default: s_nxt.st = pit_pkg::PIT_IDLE;
		endcase
		width = w8 ? {8'h00, s_nxt.cnt[15:8]} : s_nxt.cnt;
		s_nxt.out = (s_nxt.st == pit_pkg::PIT_RUN) && (s_nxt.pc < width);
		s_nxt.irq = s_r.out && !s_nxt.out && (s_nxt.st == pit_pkg::PIT_RUN);
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
	assign out_out = s_r.out;
	assign irq_out = s_r.irq;

	a_irq_on_fall: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$fell(s_r.out) && s_r.st == pit_pkg::PIT_RUN |-> s_r.irq)
		else $error("no request at output fall");
	a_halt_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_in && s_r.st != pit_pkg::PIT_RUN |=> s_r.cnt == $past(wdata_in)
		&& s_r.reload == $past(wdata_in))
		else $error("halted write did not load counter");
	a_no_retrig: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_r.st == pit_pkg::PIT_RUN && start_in && pwm_sel && mtick
		&& s_r.pc != (w8 ? `PIT_PWM_LAST8 : `PIT_PWM_LAST16)
		|=> s_r.st == pit_pkg::PIT_RUN && s_r.pc == $past(s_r.pc) + 16'h0001)
		else $error("running modulator disturbed");
	a_width_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_r.st == pit_pkg::PIT_RUN && start_in && pwm_sel && mtick && !wr_in
		&& s_r.pc == (w8 ? `PIT_PWM_LAST8 : `PIT_PWM_LAST16)
		|=> s_r.pc == 16'h0000 && s_r.cnt == s_r.reload)
		else $error("width not reloaded at period start");
	a_sw_start: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		s_r.st == pit_pkg::PIT_IDLE && start_in && pwm_sel
		&& !mode_in[`PIT_MODE_TRIG_BIT] |=> s_r.st == pit_pkg::PIT_RUN)
		else $error("software trigger did not start");
	c_pwm_fall: cover property (@(posedge clk_in) disable iff (!rst_n_in) s_r.irq);
endmodule : pit_pwm_chan

//--- hdl/pit_iv_chan.sv
// interval timer channel: periodic down counter or edge counter
// assumes tick_in and osc_tick_in are one-cycle pulses on the system clock
module pit_iv_chan #(
	parameter int CW = 16
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic tick_in,
	input wire logic osc_tick_in,
	input wire logic use_osc_in,
	input wire logic start_in,
	input wire logic [7:0] mode_in,
	input wire logic wr_in,
	input wire logic [CW-1:0] wdata_in,
	input wire logic evt_in,
	output logic [CW-1:0] cnt_out,
	output logic irq_out
);
	pit_pkg::pit_iv_t s_r;
	pit_pkg::pit_iv_t s_nxt;
	logic src;
	logic rise;
	logic fall;
	always_comb begin
		s_nxt = s_r;
		s_nxt.irq = 1'b0;
		s_nxt.evt_q = evt_in;
		rise = evt_in & ~s_r.evt_q;
		fall = ~evt_in & s_r.evt_q;
		unique case (mode_in[1:0])
			2'b00: src = tick_in;
			2'b01: begin
				if (use_osc_in)
					src = osc_tick_in;
				else if (mode_in[3])
					src = rise | fall;
				else
					src = mode_in[2] ? rise : fall;
			end
			default: src = 1'b0;
		endcase
		// start bit alone enables counting: no gate pin, no output pin
		if (start_in && src) begin
			if (s_r.cnt == '0) begin
				s_nxt.cnt = s_r.reload;
				s_nxt.irq = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt - CW'(1);
			end
		end
		if (wr_in) begin
			s_nxt.reload = wdata_in;
			if (!start_in)
				s_nxt.cnt = wdata_in;
		end
	end
	always_ff @(posedge clk_in) begin
		if (!rst_n_in)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
	assign cnt_out = s_r.cnt;
	assign irq_out = s_r.irq;

	a_zero_reload: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		start_in && src && s_r.cnt == '0 && !wr_in
		|=> s_r.irq && s_r.cnt == $past(s_r.reload))
		else $error("zero did not reload and request");
	a_count_down: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		start_in && src && s_r.cnt != '0 |=> !s_r.irq
		&& s_r.cnt == $past(s_r.cnt) - CW'(1))
		else $error("counter did not decrement");
	a_busy_write: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		wr_in && start_in && !src |=> s_r.reload == $past(wdata_in)
		&& s_r.cnt == $past(s_r.cnt))
		else $error("running write touched counter");
	c_iv_irq: cover property (@(posedge clk_in) disable iff (!rst_n_in) s_r.irq);
endmodule : pit_iv_chan

//--- tb/pit_pins_model.sv
// pin side of the timer: trigger pin, event pins and oscillator
// assumes the bench calls its tasks from one process at a time
module pit_pins_model (
	input wire logic clk_in,
	output logic trig_out,
	output logic [2:0] evt_out,
	output logic [2:0] alt_out,
	output logic osc_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] div_r = 2'h0;
	initial begin
		trig_out = 1'b0;
		evt_out = 3'h0;
		alt_out = 3'h0;
		osc_out = 1'b0;
	end
	// oscillator runs free, one rise every four clocks
	always @(posedge clk_in) begin
		div_r <= div_r + 2'h1;
		osc_out <= div_r[1];
	end
	task set_trig(input logic lvl);
		@(posedge clk_in);
		trig_out <= lvl;
		repeat (3) @(posedge clk_in);
	endtask : set_trig
	// n full pulses, each one rise and one fall
	task pulse(input int ch, input logic alt, input int n);
		repeat (2 * n) begin
			@(posedge clk_in);
			if (alt)
				alt_out[ch] <= ~alt_out[ch];
			else
				evt_out[ch] <= ~evt_out[ch];
			repeat (3) @(posedge clk_in);
		end
	endtask : pulse
endmodule : pit_pins_model

//--- tb/pwm_and_interval_event_timer_tb_top.sv
// self-checking bench of the timer block over apb and its pins
// assumes pit_top is the apb slave under test; waits end only by the bench timeout
`define PIT_CHK(g, e) cmp(32'(g), 32'(e))
module pwm_and_interval_event_timer_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic trig;
	logic [2:0] evt;
	logic [2:0] alt;
	logic osc;
	logic pin;
	logic [31:0] rd;
	logic err;
	logic [7:0] regs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h20, 8'h30};
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	int hi, per, n, m, r, d, e;
	pit_top DUT (
		.core_clk_in(clk),
		.reset_n_in(rst_n),
		.psel_in(psel),
		.penable_in(penable),
		.pwrite_in(pwrite),
		.paddr_in(paddr),
		.pwdata_in(pwdata),
		.prdata_out(prdata),
		.pready_out(pready),
		.pslverr_out(pslverr),
		.general_trigger_input_in(trig),
		.modulated_output_pin_out(pin),
		.interval_event_input_in(evt),
		.interval_event_alt_in(alt),
		.main_oscillator_input_in(osc)
	);
	pit_pins_model u_pins (
		.clk_in(clk),
		.trig_out(trig),
		.evt_out(evt),
		.alt_out(alt),
		.osc_out(osc)
	);
	initial begin
		forever #2 clk = ~clk;
	end
	// one long modulator period plus short tests stays below this
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 99000) begin
			failures++;
			end_of_test();
		end
	end
	task cmp(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : cmp
	task end_of_test();
		$display("checks=%0d failures=%0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task apb(input logic w, input logic [7:0] a, input logic [31:0] dw);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dw;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] dw);
		apb(1'b1, a, dw);
		`PIT_CHK(err, 1'b0);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`PIT_CHK(rd, x);
	endtask : rdc
	task stay(input logic l, inout int c);
		int k;
		k = 0;
		while (pin === l) begin
			@(posedge clk);
			k++;
		end
		c += k;
	endtask : stay
	// skip a pulse in progress, then time one whole pulse
	task measure();
		stay(1'b1, d);
		stay(1'b0, d);
		hi = 0;
		stay(1'b1, hi);
		per = hi;
		stay(1'b0, per);
	endtask : measure
	initial begin
		void'($urandom(32'hffc4));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (regs[i])
			rdc(regs[i], 0);
		apb(1'b1, 8'h44, 32'hffff);
		`PIT_CHK(err, 1'b1);
		rdc(8'h40, 0);
		`PIT_CHK(err, 1'b1);
		// interval channel 0, timer mode on the system clock
		r = 16'h0800 + $urandom % 256;
		wr(8'h20, 8'h00);
		wr(8'h30, r);
		rdc(8'h30, r);
		wr(8'h00, 8'h20);
		apb(1'b0, 8'h30, 32'h0);
		`PIT_CHK(rd < r && rd > r - 40, 1'b1);
		wr(8'h30, 16'h0010);
		apb(1'b0, 8'h30, 32'h0);
		`PIT_CHK(rd > 16'h0100, 1'b1);
		repeat (r + 20) @(posedge clk);
		apb(1'b0, 8'h30, 32'h0);
		`PIT_CHK(rd <= 16'h0010, 1'b1);
		rdc(8'h0c, 8'h20);
		wr(8'h00, 8'h00);
		wr(8'h0c, 8'h20);
		rdc(8'h0c, 8'h00);
		// channel 0 on the divide-by-8 clock, reload rewritten while running
		wr(8'h20, 8'h40);
		wr(8'h30, 16'h0100);
		wr(8'h00, 8'h20);
		wr(8'h30, 16'h0040);
		repeat (400) @(posedge clk);
		apb(1'b0, 8'h30, 32'h0);
		d = int'(16'h0100 - rd[15:0]);
		`PIT_CHK(d >= 49 && d <= 53, 1'b1);
		wr(8'h00, 8'h00);
		// channel 1 edge codes on primary and alternative pins
		for (int c = 0; c < 6; c++) begin
			wr(8'h14, {c[0], 1'b0});
			wr(8'h24, {4'h0, 2'(c / 2), 2'b01});
			wr(8'h34, 16'h0100);
			wr(8'h00, 8'h40);
			n = 1 + $urandom % 5;
			u_pins.pulse(1, c[0], n);
			u_pins.pulse(1, !c[0], 2);
			e = (c / 2 == 2) ? 2 * n : n;
			rdc(8'h34, 16'h0100 - e);
			wr(8'h00, 8'h00);
		end
		// channel 2 counts the divided oscillator, its pin ignored
		wr(8'h10, 8'h40);
		wr(8'h28, 8'h01);
		wr(8'h38, 16'h0100);
		wr(8'h00, 8'h80);
		u_pins.pulse(2, 1'b0, 3);
		repeat (1260) @(posedge clk);
		apb(1'b0, 8'h38, 32'h0);
		d = int'(16'h0100 - rd[15:0]);
		`PIT_CHK(d >= 9 && d <= 11, 1'b1);
		wr(8'h00, 8'h00);
		wr(8'h10, 8'h00);
		// 16-bit modulation, software start
		m = 50 + $urandom % 200;
		wr(8'h04, 8'h07);
		wr(8'h08, m);
		fork
			measure();
			wr(8'h00, 8'h01);
		join
		`PIT_CHK(hi, m);
		`PIT_CHK(per, 16'hffff);
		rdc(8'h0c, 8'h01);
		rdc(8'h08, 0);
		wr(8'h00, 8'h00);
		wr(8'h0c, 8'h01);
		// 8-bit modulation with prescaler, width change while running
		n = 1 + $urandom % 3;
		m = 5 + $urandom % 16;
		wr(8'h04, 8'h27);
		wr(8'h08, {m[7:0], n[7:0]});
		fork
			measure();
			wr(8'h00, 8'h01);
		join
		`PIT_CHK(hi, (n + 1) * m);
		`PIT_CHK(per, (n + 1) * 255);
		wr(8'h08, {m[7:0] + 8'h03, n[7:0]});
		measure();
		`PIT_CHK(hi, (n + 1) * (m + 3));
		wr(8'h00, 8'h00);
		// external trigger on each edge, wrong edge and retrigger ignored
		for (int g = 0; g < 2; g++) begin
			wr(8'h04, {4'h3, g[0], 3'h7});
			wr(8'h08, {m[7:0], n[7:0]});
			u_pins.set_trig(g[0]);
			wr(8'h00, 8'h01);
			u_pins.set_trig(!g[0]);
			hi = 0;
			repeat (40) begin
				@(posedge clk);
				hi += (pin !== 1'b0);
			end
			`PIT_CHK(hi, 0);
			fork
				measure();
				begin
					u_pins.set_trig(g[0]);
					repeat ((n + 1) * m + 20) @(posedge clk);
					u_pins.set_trig(!g[0]);
					u_pins.set_trig(g[0]);
				end
			join
			`PIT_CHK(hi, (n + 1) * m);
			`PIT_CHK(per, (n + 1) * 255);
			wr(8'h00, 8'h00);
		end
		end_of_test();
	end
endmodule : pwm_and_interval_event_timer_tb_top
